/* rtl/sst_consts.svh */
`ifndef SST_CONSTS_SVH
`define SST_CONSTS_SVH

`define SST_CTRL_OFFSET    12'h228
`define SST_STATUS_OFFSET  12'h22c
`define SST_CTRL_RESET     8'h00
`define SST_MODE_LSB       1
`define SST_MASTER_BIT     0
`define SST_PAL_BIT        3
`define SST_LINE_PAL       10'h360
`define SST_LINE_NTSC      10'h35a
`define SST_LINES_PAL      10'h271
`define SST_LINES_NTSC     10'h20d
`define SST_VBLANK_PAL     10'h016
`define SST_VBLANK_NTSC    10'h013
`define SST_HSYNC_WIDTH    10'h040
`define SST_ACTIVE_START   10'h08a

`endif

/* rtl/sst_pkg.sv */
package sst_pkg;
  typedef enum logic [1:0] {
    SST_MODE_EMBED,
    SST_MODE_HFIELD_LO,
    SST_MODE_HVSYNC,
    SST_MODE_HFIELD_HI
  } sst_mode_e;

  typedef enum {
    SST_SEQ_IDLE,
    SST_SEQ_FF,
    SST_SEQ_Z1,
    SST_SEQ_Z2
  } sst_seq_e;

  typedef logic [9:0] sst_count_t;
endpackage

/* rtl/sst_code_if.sv */
`timescale 1ns/100ps
interface sst_code_if;
  logic       code_valid;
  logic       code_blank;
  logic       code_field;
  logic       code_vblank;
  logic       code_active_end;

  modport detector (
    output code_valid,
    output code_blank,
    output code_field,
    output code_vblank,
    output code_active_end
  );
  modport user (
    input code_valid,
    input code_blank,
    input code_field,
    input code_vblank,
    input code_active_end
  );
endinterface

/* rtl/sst_code_detect.sv */
`timescale 1ns/100ps
module sst_code_detect
  import sst_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clk_en,
  input  wire logic [7:0] pixel,
  sst_code_if.detector    code
);
  sst_seq_e seq_reg;

  // Four-byte sequence ff 00 00 xy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= SST_SEQ_IDLE;
    end else if (clk_en) begin
      case (seq_reg)
        SST_SEQ_FF: seq_reg <= (pixel == 8'h00) ? SST_SEQ_Z1 :
                               (pixel == 8'hff) ? SST_SEQ_FF : SST_SEQ_IDLE;
        SST_SEQ_Z1: seq_reg <= (pixel == 8'h00) ? SST_SEQ_Z2 :
                               (pixel == 8'hff) ? SST_SEQ_FF : SST_SEQ_IDLE;
        default:    seq_reg <= (pixel == 8'hff) ? SST_SEQ_FF : SST_SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code.code_valid      <= 1'b0;
      code.code_blank      <= 1'b0;
      code.code_field      <= 1'b0;
      code.code_vblank     <= 1'b0;
      code.code_active_end <= 1'b0;
    end else if (clk_en) begin
      code.code_valid <= (seq_reg == SST_SEQ_Z2) && pixel[7];
      if (seq_reg == SST_SEQ_Z2 && pixel[7]) begin
        code.code_field      <= pixel[6];
        code.code_vblank     <= pixel[5];
        code.code_active_end <= pixel[4];
        code.code_blank      <= pixel[5];
      end
    end
  end
endmodule

/* rtl/sst_sync_timing.sv */
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`include "sst_consts.svh"

////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Mode 0 slave takes all timing from embedded start/end codes only.
// - Mode 0 master drives line-blank on line pin, field bit on frame pin.
// - Mode 1 slave: field change while hsync low starts a new frame.
// - Modes 1 to 3 blank standard blanking lines whatever pixels arrive.
// - Mode 1 master drives hsync and field; data taken edge after.
// - Mode 2: hsync and vsync falling together start the odd field.
// - Mode 2: vsync falling while hsync high starts the even field.
// - Mode 2 master drives hsync and vsync; vsync falls with hsync for every field.
// - Mode 3: field change while hsync high starts a new frame.
// - Mode 3 sync pins are outputs as master, inputs as slave.
// - A line spans 864 (PAL) or 858 (NTSC) half-rate clock periods.
module sst_sync_timing
  import sst_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [7:0]  pixel_in,
  input  wire logic        hsync_n_in,
  input  wire logic        vsync_n_in,
  output logic             hsync_n_out,
  output logic             hsync_n_oe,
  output logic             vsync_n_out,
  output logic             vsync_n_oe,
  output logic [7:0]       pixel_out,
  output logic             field_out,
  output logic             frame_start
);
  logic [7:0] ctrl_reg;
  logic       half_reg;
  sst_count_t hcount_reg;
  sst_count_t vcount_reg;
  logic       field_reg;
  logic [7:0] pix_s1_reg;
  logic [7:0] pix_s2_reg;
  logic [1:0] hs_sync_reg;
  logic [1:0] vs_sync_reg;
  logic       hs_prev_reg;
  logic       vs_prev_reg;
  logic       slave_line_blank_reg;
  logic       pixel_blank_reg;
  logic       drive_h_reg;
  logic       drive_v_reg;

  sst_mode_e  mode;
  logic       master;
  logic       pal;
  sst_count_t line_len;
  sst_count_t frame_lines;
  sst_count_t vblank_lines;
  logic       line_end;
  logic       hs;
  logic       vs;
  logic       hs_fall;
  logic       vs_fall;
  logic       vs_edge;
  logic       slave_line_start;
  logic       slave_frame;
  logic       slave_field;
  logic       h_next;
  logic       v_next;
  logic       vblank_now;

  sst_code_if code_bus ();

  sst_code_detect u_detect (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .pixel   (pix_s2_reg),
    .code    (code_bus.detector)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Mode decode
  assign mode   = sst_mode_e'(ctrl_reg[`SST_MODE_LSB +: 2]);
  assign master = ctrl_reg[`SST_MASTER_BIT];
  assign pal    = ctrl_reg[`SST_PAL_BIT];
  assign line_len     = pal ? `SST_LINE_PAL : `SST_LINE_NTSC;
  assign frame_lines  = pal ? `SST_LINES_PAL : `SST_LINES_NTSC;
  assign vblank_lines = pal ? `SST_VBLANK_PAL : `SST_VBLANK_NTSC;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `SST_CTRL_RESET;
    end else if (clk_en && psel && penable && pwrite &&
                 paddr == `SST_CTRL_OFFSET) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr != `SST_CTRL_OFFSET &&
                 paddr != `SST_STATUS_OFFSET;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          `SST_CTRL_OFFSET:   prdata <= {24'h00_0000, ctrl_reg};
          `SST_STATUS_OFFSET: prdata <= {11'h000, field_reg, vcount_reg,
                                         hcount_reg};
          default:            prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_s1_reg  <= 8'h00;
      pix_s2_reg  <= 8'h00;
      hs_sync_reg <= 2'h3;
      vs_sync_reg <= 2'h3;
      hs_prev_reg <= 1'b1;
      vs_prev_reg <= 1'b1;
    end else if (clk_en) begin
      pix_s1_reg  <= pixel_in;
      pix_s2_reg  <= pix_s1_reg;
      hs_sync_reg <= {hs_sync_reg[0], hsync_n_in};
      vs_sync_reg <= {vs_sync_reg[0], vsync_n_in};
      hs_prev_reg <= hs_sync_reg[1];
      vs_prev_reg <= vs_sync_reg[1];
    end
  end

  assign hs      = hs_sync_reg[1];
  assign vs      = vs_sync_reg[1];
  assign hs_fall = hs_prev_reg && !hs;
  assign vs_fall = vs_prev_reg && !vs;
  assign vs_edge = vs_prev_reg != vs;

  ////////////////////////////////////////////////////////////////////////////
  // Slave field decode
  always_comb begin
    slave_line_start = hs_fall;
    slave_frame      = 1'b0;
    slave_field      = field_reg;
    case (mode)
      SST_MODE_EMBED: begin
        slave_line_start = code_bus.code_valid &&
                           code_bus.code_active_end;
        slave_frame      = code_bus.code_valid &&
                           code_bus.code_field != field_reg;
        slave_field      = code_bus.code_field;
      end
      SST_MODE_HFIELD_LO: begin
        slave_frame = vs_edge && !hs;
        slave_field = !vs;
      end
      SST_MODE_HVSYNC: begin
        slave_frame = vs_fall;
        slave_field = !(vs_fall && hs_fall) && hs;
      end
      SST_MODE_HFIELD_HI: begin
        slave_frame = vs_edge && hs;
        slave_field = !vs;
      end
      default: begin
        slave_frame = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-rate line counter
  assign line_end = half_reg && hcount_reg == line_len - 10'h001;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_reg   <= 1'b0;
      hcount_reg <= 10'h000;
    end else if (clk_en) begin
      if (!master && slave_line_start) begin
        half_reg   <= 1'b0;
        hcount_reg <= 10'h000;
      end else begin
        half_reg <= !half_reg;
        if (line_end) begin
          hcount_reg <= 10'h000;
        end else if (half_reg) begin
          hcount_reg <= hcount_reg + 10'h001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vcount_reg  <= 10'h000;
      field_reg   <= 1'b0;
      frame_start <= 1'b0;
    end else if (clk_en) begin
      frame_start <= 1'b0;
      if (!master && slave_frame) begin
        vcount_reg  <= 10'h000;
        field_reg   <= slave_field;
        frame_start <= 1'b1;
      end else if (master && line_end) begin
        if (vcount_reg == frame_lines - 10'h001) begin
          vcount_reg  <= 10'h000;
          field_reg   <= !field_reg;
          frame_start <= 1'b1;
        end else begin
          vcount_reg <= vcount_reg + 10'h001;
        end
      end else if (!master && slave_line_start) begin
        vcount_reg <= vcount_reg + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master sync generation
  assign vblank_now = vcount_reg < vblank_lines;

  always_comb begin
    h_next = hcount_reg >= `SST_HSYNC_WIDTH;
    v_next = !(vcount_reg < 10'h003);
    case (mode)
      SST_MODE_EMBED: begin
        h_next = hcount_reg >= `SST_ACTIVE_START;
        v_next = field_reg;
      end
      SST_MODE_HFIELD_LO: begin
        v_next = !field_reg;
      end
      SST_MODE_HVSYNC: begin
        v_next = !(vcount_reg < 10'h003);
      end
      SST_MODE_HFIELD_HI: begin
        v_next = !field_reg;
      end
      default: begin
        v_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hsync_n_out <= 1'b1;
      vsync_n_out <= 1'b1;
      hsync_n_oe  <= 1'b0;
      vsync_n_oe  <= 1'b0;
      drive_h_reg <= 1'b1;
      drive_v_reg <= 1'b1;
    end else if (clk_en) begin
      drive_h_reg <= h_next;
      drive_v_reg <= v_next;
      hsync_n_out <= drive_h_reg;
      vsync_n_out <= drive_v_reg;
      hsync_n_oe  <= master;
      vsync_n_oe  <= master;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pixel capture and blanking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slave_line_blank_reg <= 1'b1;
      pixel_blank_reg      <= 1'b1;
    end else if (clk_en) begin
      if (code_bus.code_valid) begin
        slave_line_blank_reg <= code_bus.code_blank ||
                                !code_bus.code_active_end;
      end
      if (mode == SST_MODE_EMBED) begin
        pixel_blank_reg <= code_bus.code_valid ? (code_bus.code_blank ||
                           code_bus.code_active_end) :
                           pixel_blank_reg;
      end else begin
        pixel_blank_reg <= vblank_now ||
                           hcount_reg < `SST_ACTIVE_START;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pixel_out <= 8'h00;
      field_out <= 1'b0;
    end else if (clk_en) begin
      pixel_out <= pixel_blank_reg ? 8'h00 : pix_s2_reg;
      field_out <= field_reg;
    end
  end
endmodule

/* dv/sst_sync_timing_checker.sv */
`timescale 1ns/100ps
`include "sst_consts.svh"
module sst_chk
  import sst_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        hsync_n_out,
  input wire logic        hsync_n_oe,
  input wire logic        vsync_n_oe,
  input wire logic        frame_start
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [7:0]  ctrl_q;
  logic [11:0] gap;
  logic [11:0] per;
  logic        hs_q;
  logic        armed;
  wire         wr = psel && penable && pready && pwrite
                    && paddr == `SST_CTRL_OFFSET;
  wire         fall = hs_q && !hsync_n_out;
  // Line spans two clocks per half-rate period
  wire  [11:0] len = ctrl_q[3] ? {1'b0, `SST_LINE_PAL, 1'b0}
                               : {1'b0, `SST_LINE_NTSC, 1'b0};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 8'h00;
      gap    <= 12'h000;
    end else begin
      ctrl_q <= wr ? pwdata[7:0] : ctrl_q;
      gap    <= wr ? 12'h000 : gap + {11'h000, gap != 12'hfff};
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_q  <= 1'b1;
      per   <= 12'h000;
      armed <= 1'b0;
    end else begin
      hs_q  <= hsync_n_out;
      per   <= fall ? 12'h001 : per + {11'h000, per != 12'hfff};
      armed <= !wr && (armed || (fall && gap > 12'h010));
    end
  end
  //////////////////////////////////////////////////////////////////////
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready)
    else $error("no ready after setup");
  property p_pulse; $rose(pready) |=> !pready; endproperty
  a_pulse: assert property (p_pulse)
    else $error("ready longer than one cycle");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err)
    else $error("error without ready");
  property p_unmap;
    psel && !penable && paddr != `SST_CTRL_OFFSET
      && paddr != `SST_STATUS_OFFSET |=> pslverr;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped access not refused");
  property p_rd;
    pready && !pwrite && paddr == `SST_CTRL_OFFSET
      |-> prdata == {24'h000000, ctrl_q};
  endproperty
  a_rd: assert property (p_rd)
    else $error("control readback wrong");
  property p_oe;
    gap > 12'h008 |-> hsync_n_oe == ctrl_q[0] && vsync_n_oe == ctrl_q[0];
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin direction wrong");
  property p_line; armed && ctrl_q[0] && fall |-> per == len; endproperty
  a_line: assert property (p_line)
    else $error("line length wrong");
  property p_frame; frame_start |=> !frame_start; endproperty
  a_frame: assert property (p_frame)
    else $error("frame pulse too long");
  c_frame: cover property (frame_start);
  c_err: cover property (pslverr);
  c_line: cover property (armed && fall);
endmodule
bind sst_sync_timing sst_chk sst_chk_inst (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .hsync_n_out, .hsync_n_oe, .vsync_n_oe, .frame_start
);

/* dv/sst_video_src.sv */
`timescale 1ns/100ps
`include "sst_consts.svh"
module sst_video_src
  import sst_pkg::*;
#(
  parameter int FIELD_LINES = 5
)
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [2:0] cfg,
  output logic            hsync_n,
  output logic            vsync_n,
  output logic [7:0]      pixel,
  output sst_count_t      h,
  output logic [3:0]      v
);
  localparam logic [3:0] F = 4'(FIELD_LINES);
  logic       fq;
  logic       ph;
  logic       eol;
  logic [1:0] bi;
  sst_count_t len;
  logic       fld;
  logic       vbl;
  assign len = cfg[2] ? `SST_LINE_PAL : `SST_LINE_NTSC;
  assign fld = v >= F;
  assign vbl = v < 4'h2 || v == F || v == F + 4'h1;
  assign eol = ph && h == len - 10'h001;
  assign bi  = {h[0], ph};
  // Shortened fields, half-rate line position
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h  <= 10'h000;
      v  <= 4'h0;
      fq <= 1'b0;
      ph <= 1'b0;
    end else begin
      ph <= !ph;
      if (eol) begin
        h <= 10'h000;
      end else if (ph) begin
        h <= h + 10'h001;
      end
      if (eol) begin
        v <= (v == F + F - 4'h1) ? 4'h0 : v + 4'h1;
      end
      fq <= (h == 10'h064) ? fld : fq;
    end
  end
  always_comb begin
    hsync_n = 1'b1;
    vsync_n = 1'b1;
    pixel   = 8'h5a;
    if (cfg[1:0] == 2'h0) begin
      if (h < 10'h002 || (h >= `SST_ACTIVE_START - 10'h002
          && h < `SST_ACTIVE_START)) begin
        pixel = bi == 2'h0 ? 8'hff : bi != 2'h3 ? 8'h00
              : {1'b1, fld, vbl, h < 10'h002, 4'h0};
      end
    end else begin
      hsync_n = h >= `SST_HSYNC_WIDTH;
      case (cfg[1:0])
        2'h1: vsync_n = fld;
        2'h2: vsync_n = !(v < 4'h3 || (v >= F && v < F + 4'h3
                          && !(v == F && h < 10'h064)));
        default: vsync_n = fq;
      endcase
    end
  end
endmodule

/* dv/tb_top.sv */
`timescale 1ns/100ps
`include "sst_consts.svh"
module tb_top;
  import sst_pkg::*;
  localparam int F = 4;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        clk_en = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic        pready, pslverr, hs_o, hs_oe, vs_o, vs_oe, src_hs, src_vs;
  logic [7:0]  pixel, pixel_out;
  logic        field_out, frame_start;
  logic [2:0]  cfg = 3'h0;
  sst_count_t  h;
  logic [3:0]  v;
  int          failures = 0;
  int          samples_checked = 0;
  wire         hs_w = hs_oe ? hs_o : src_hs;
  wire         vs_w = vs_oe ? vs_o : src_vs;
  always #2 pclk = ~pclk;
  sst_sync_timing sst_sync_timing_inst (
    .pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pixel_in(pixel), .hsync_n_in(hs_w),
    .vsync_n_in(vs_w), .hsync_n_out(hs_o), .hsync_n_oe(hs_oe),
    .vsync_n_out(vs_o), .vsync_n_oe(vs_oe), .pixel_out, .field_out,
    .frame_start
  );
  sst_video_src #(.FIELD_LINES(F)) sst_video_src_inst (
    .pclk, .presetn, .cfg, .hsync_n(src_hs), .vsync_n(src_vs), .pixel, .h, .v
  );
  //////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic stop;
    failures++;
    close_out();
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) stop();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fall(output int n);
    logic p;
    n = 0;
    do begin
      p = hs_o;
      @(posedge pclk);
      n++;
    end while (!(p && !hs_o) && n < 3000);
    if (n >= 3000) stop();
  endtask
  initial begin
    logic [31:0] q;
    logic        e, a, b;
    logic [7:0]  p1, p3;
    int          n, fs;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `SST_CTRL_OFFSET, 32'h0, q, e);
    cmp(q, {24'h0, `SST_CTRL_RESET});
    apb(1'b0, 12'h100, 32'h0, q, e);
    cmp({e, q[30:0]}, 32'h80000000);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `SST_CTRL_OFFSET, {24'hffffff, 4'h0, c[2], c[2:0]}, q, e);
      apb(1'b0, `SST_CTRL_OFFSET, 32'h0, q, e);
      cmp(q, {28'h0, c[2], c[2:0]});
      cfg <= {c[2], c[2:1]};
      repeat (16) @(posedge pclk);
      cmp({30'h0, hs_oe, vs_oe}, {30'h0, c[0], c[0]});
      if (c[0]) begin
        fall(n);
        fall(n);
        cmp(n, c[2] ? 1728 : 1716);
      end else begin
        n = 0;
        while (!(v == 4'h0 && h == 10'h000) && n < 14000) begin
          @(posedge pclk);
          n++;
        end
        if (n >= 14000) stop();
        fs = 0;
        for (n = 0; n < 14000 && !(v == F + 3 && h == 10'h191); n++) begin
          @(posedge pclk);
          fs += frame_start;
          if (h == 10'h190 && v == 4'h1) p1 = pixel_out;
          if (h == 10'h190 && v == 4'h3) begin
            a = field_out;
            p3 = pixel_out;
          end
          if (h == 10'h190 && v == F + 3) b = field_out;
        end
        cmp({24'h0, p3}, c == 0 ? 32'h5a : 32'h0);
        if (c == 0) cmp({24'h0, p1}, 32'h0);
        cmp({31'h0, a ^ b}, 32'h1);
        if (c != 0) cmp({31'h0, fs != 0}, 32'h1);
      end
    end
    close_out();
  end
endmodule
